//--- hdl/uim_map.svh
// register offsets, field positions, reset values and bus codes
`ifndef UIM_MAP_SVH
`define UIM_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define UIM_OFF_MASK   8'h38
`define UIM_OFF_RAW    8'h3C
`define UIM_OFF_MASKED 8'h40
`define UIM_OFF_CLEAR  8'h44

// ----------------------------------------------------------------
// source bit positions, shared by all four registers
// ----------------------------------------------------------------
`define UIM_BIT_MODEM_CTS     1
`define UIM_BIT_RX            4
`define UIM_BIT_TX            5
`define UIM_BIT_RX_TIMEOUT    6
`define UIM_BIT_FRAMING_ERR   7
`define UIM_BIT_PARITY_ERR    8
`define UIM_BIT_BREAK_ERR     9
`define UIM_BIT_OVERRUN_ERR   10
`define UIM_BIT_FLOW_STOP     11
`define UIM_BIT_TX_FIFO_EMPTY 12

// ----------------------------------------------------------------
// implemented bits, reset values, bus responses
// ----------------------------------------------------------------
`define UIM_IMPL_BITS 32'h0000_1FF2
`define UIM_RST_VAL   32'h0000_0000
`define UIM_RESP_OKAY   2'h0
`define UIM_RESP_SLVERR 2'h2

`endif

//--- hdl/uim_pkg.sv
// types shared by the interrupt mask and status block
package uim_pkg;

  // ----------------------------------------------------------------
  // bus slave state machines
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    UIM_WR_IDLE = 1'b0,  // collecting address and data
    UIM_WR_RESP = 1'b1   // write response offered
  } uim_wr_st_t;

  typedef enum logic [1:0] {
    UIM_RD_IDLE  = 2'b00,  // waiting for a read address
    UIM_RD_FETCH = 2'b01,  // register file sampled
    UIM_RD_RESP  = 2'b10   // read data offered
  } uim_rd_st_t;

  // ----------------------------------------------------------------
  // core register state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mask;  // enable per source
    logic [31:0] raw;   // sticky pending flags
    logic        irq;   // interrupt output flop
  } uim_core_t;

endpackage : uim_pkg

//--- hdl/uim_axil_slave.sv
// axi4-lite slave front end turning bus transfers into strobes
`include "uim_map.svh"

module uim_axil_slave #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // write address and data channels
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // write response channel
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // read channels
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // register file side
  output logic                   wrStrobe,
  output logic [ADDR_W-1:0]      wrAddr,
  output logic [31:0]            wrData,
  output logic [3:0]             wrByteEn,
  input  wire logic              wrOk,
  output logic                   rdStrobe,
  output logic [ADDR_W-1:0]      rdAddr,
  input  wire logic [31:0]       rdData,
  input  wire logic              rdOk
);

  // ----------------------------------------------------------------
  // slave state
  // ----------------------------------------------------------------
  typedef struct packed {
    uim_pkg::uim_wr_st_t wrSt;
    logic                awHeld;   // write address taken
    logic                wHeld;    // write data taken
    logic [ADDR_W-1:0]   wAddr;
    logic [31:0]         wData;
    logic [3:0]          wStrb;
    logic                awReady;
    logic                wReady;
    logic                bValid;
    logic [1:0]          bResp;
    uim_pkg::uim_rd_st_t rdSt;
    logic [ADDR_W-1:0]   rAddr;
    logic                arReady;
    logic                rValid;
    logic [31:0]         rData;
    logic [1:0]          rResp;
  } uim_slv_t;

  uim_slv_t slv_reg;   // registered state
  uim_slv_t slv_next;  // next state

  // next-state logic for both channels
  always_comb begin
    slv_next = slv_reg;
    // write side: address and data in either order
    if (slv_reg.wrSt == uim_pkg::UIM_WR_IDLE) begin
      if (s_axi_awvalid && slv_reg.awReady) begin
        slv_next.awHeld = 1'b1;
        slv_next.wAddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && slv_reg.wReady) begin
        slv_next.wHeld = 1'b1;
        slv_next.wData = s_axi_wdata;
        slv_next.wStrb = s_axi_wstrb;
      end
      // both held: register file acts now, response next
      if (slv_reg.awHeld && slv_reg.wHeld) begin
        slv_next.wrSt   = uim_pkg::UIM_WR_RESP;
        slv_next.bValid = 1'b1;
        slv_next.bResp  = wrOk ? `UIM_RESP_OKAY : `UIM_RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      slv_next.wrSt   = uim_pkg::UIM_WR_IDLE;
      slv_next.bValid = 1'b0;
      slv_next.awHeld = 1'b0;
      slv_next.wHeld  = 1'b0;
    end
    slv_next.awReady = (slv_next.wrSt == uim_pkg::UIM_WR_IDLE) &&
                       !slv_next.awHeld;
    slv_next.wReady  = (slv_next.wrSt == uim_pkg::UIM_WR_IDLE) &&
                       !slv_next.wHeld;
    // read side
    case (slv_reg.rdSt)
      uim_pkg::UIM_RD_IDLE: begin
        if (s_axi_arvalid && slv_reg.arReady) begin
          slv_next.rAddr = s_axi_araddr;
          slv_next.rdSt  = uim_pkg::UIM_RD_FETCH;
        end
      end
      uim_pkg::UIM_RD_FETCH: begin
        slv_next.rData  = rdData;
        slv_next.rResp  = rdOk ? `UIM_RESP_OKAY : `UIM_RESP_SLVERR;
        slv_next.rValid = 1'b1;
        slv_next.rdSt   = uim_pkg::UIM_RD_RESP;
      end
      uim_pkg::UIM_RD_RESP: begin
        if (s_axi_rready) begin
          slv_next.rValid = 1'b0;
          slv_next.rdSt   = uim_pkg::UIM_RD_IDLE;
        end
      end
      default: begin
        slv_next.rdSt = uim_pkg::UIM_RD_IDLE;
      end
    endcase
    slv_next.arReady = (slv_next.rdSt == uim_pkg::UIM_RD_IDLE);
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      slv_reg <= '0;
    end else begin
      slv_reg <= slv_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = slv_reg.awReady;
  assign s_axi_wready  = slv_reg.wReady;
  assign s_axi_bvalid  = slv_reg.bValid;
  assign s_axi_bresp   = slv_reg.bResp;
  assign s_axi_arready = slv_reg.arReady;
  assign s_axi_rvalid  = slv_reg.rValid;
  assign s_axi_rdata   = slv_reg.rData;
  assign s_axi_rresp   = slv_reg.rResp;
  assign wrStrobe = (slv_reg.wrSt == uim_pkg::UIM_WR_IDLE) &&
                    slv_reg.awHeld && slv_reg.wHeld;
  assign wrAddr   = slv_reg.wAddr;
  assign wrData   = slv_reg.wData;
  assign wrByteEn = slv_reg.wStrb;
  assign rdStrobe = (slv_reg.rdSt == uim_pkg::UIM_RD_FETCH);
  assign rdAddr   = slv_reg.rAddr;

endmodule : uim_axil_slave

//--- hdl/uim_top.sv
// uart interrupt mask, raw status and masked status block
//
// Operation
// - mask bit 1 enables, 0 disables source
// - mask register reads back stored enables
// - sources at bits 1 and 4 to 12
// - mask resets to zero, reserved bits zero
// - raw status readable at 0x3C, ignores mask
// - raw bit reads 1 while pending
// - raw bits share mask bit positions
// - raw status resets zero, writes ignored
// - masked status at 0x40, cts at bit 1
// - masked status covers bits 1 and 4 to 12
// - clear register at 0x44, 1 clears
`include "uim_map.svh"

module uim_top #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,

  // axi4-lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,

  // axi4-lite write response
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,

  // axi4-lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,

  // source events, one cycle or level, high when detected
  input  wire logic              modemCtsEvt,
  input  wire logic              rxEvt,
  input  wire logic              txEvt,
  input  wire logic              rxTimeoutEvt,
  input  wire logic              framingErrEvt,
  input  wire logic              parityErrEvt,
  input  wire logic              breakErrEvt,
  input  wire logic              overrunErrEvt,
  input  wire logic              flowStopEvt,
  input  wire logic              txFifoEmptyEvt,

  // interrupt request
  output logic                   uartIrq
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------

  // address compare against a byte offset
  function automatic logic regHit(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        off);
    regHit = (a == ADDR_W'(off));
  endfunction : regHit

  // expand four byte enables into a 32-bit lane mask
  function automatic logic [31:0] laneMask(input logic [3:0] be);
    laneMask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : laneMask

  // ----------------------------------------------------------------
  // bus front end wiring
  // ----------------------------------------------------------------
  logic              wrStrobe;   // one-cycle write action
  logic [ADDR_W-1:0] wrAddr;     // write byte address
  logic [31:0]       wrData;     // write data
  logic [3:0]        wrByteEn;   // write byte enables
  logic              wrOk;       // write address mapped
  logic              rdStrobe;   // one-cycle read sample
  logic [ADDR_W-1:0] rdAddr;     // read byte address
  logic [31:0]       rdData;     // read data to the slave
  logic              rdOk;       // read address mapped

  // axi4-lite slave
  uim_axil_slave #(
    .ADDR_W (ADDR_W)
  ) u_slave (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .wrStrobe      (wrStrobe),
    .wrAddr        (wrAddr),
    .wrData        (wrData),
    .wrByteEn      (wrByteEn),
    .wrOk          (wrOk),
    .rdStrobe      (rdStrobe),
    .rdAddr        (rdAddr),
    .rdData        (rdData),
    .rdOk          (rdOk)
  );

  // ----------------------------------------------------------------
  // event vector
  // ----------------------------------------------------------------
  logic [31:0] evtVec;  // events at their register positions

  // place each source at its shared bit position
  always_comb begin
    // reserved stay zero
    evtVec = `UIM_RST_VAL;
    evtVec[`UIM_BIT_MODEM_CTS]     = modemCtsEvt;
    evtVec[`UIM_BIT_RX]            = rxEvt;
    evtVec[`UIM_BIT_TX]            = txEvt;
    evtVec[`UIM_BIT_RX_TIMEOUT]    = rxTimeoutEvt;
    evtVec[`UIM_BIT_FRAMING_ERR]   = framingErrEvt;
    evtVec[`UIM_BIT_PARITY_ERR]    = parityErrEvt;
    evtVec[`UIM_BIT_BREAK_ERR]     = breakErrEvt;
    evtVec[`UIM_BIT_OVERRUN_ERR]   = overrunErrEvt;
    evtVec[`UIM_BIT_FLOW_STOP]     = flowStopEvt;
    evtVec[`UIM_BIT_TX_FIFO_EMPTY] = txFifoEmptyEvt;
  end

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  uim_pkg::uim_core_t core_reg;   // registered state
  uim_pkg::uim_core_t core_next;  // next state

  logic [31:0] maskedVal;  // raw gated by mask
  logic [31:0] clrVec;     // bits cleared this cycle
  logic        hitMask;    // write hits the mask register
  logic        hitClear;   // write hits the clear register
  logic        rdRawClr;   // read of raw status clears it

  // masked view, reserved bits stay zero
  assign maskedVal = core_reg.raw & core_reg.mask;

  // write decode and raw status read decode
  assign hitMask  = wrStrobe && regHit(wrAddr, `UIM_OFF_MASK);
  assign hitClear = wrStrobe && regHit(wrAddr, `UIM_OFF_CLEAR);
  assign rdRawClr = rdStrobe && regHit(rdAddr, `UIM_OFF_RAW);

  // next-state logic
  always_comb begin
    // hold by default
    core_next = core_reg;
    clrVec    = `UIM_RST_VAL;
    // mask: only addressed byte lanes, only implemented bits
    if (hitMask) begin
      core_next.mask = (core_reg.mask & ~laneMask(wrByteEn)) |
                       (wrData & laneMask(wrByteEn) &
                        `UIM_IMPL_BITS);
    end
    // clear register: a one clears, a zero leaves alone
    if (hitClear) begin
      clrVec = wrData & laneMask(wrByteEn);
    end
    // reading raw status clears what it returned
    if (rdRawClr) begin
      clrVec = clrVec | core_reg.raw;
    end
    // writes to the raw or masked status change nothing
    // set wins over clear, mask plays no part
    core_next.raw = ((core_reg.raw & ~clrVec) | evtVec) &
                    `UIM_IMPL_BITS;
    // irq built from the next raw and mask, so it matches their flops
    core_next.irq = |(core_next.raw & core_next.mask);
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      core_reg <= '0;
    end else begin
      // normal update
      core_reg <= core_next;
    end
  end

  // ----------------------------------------------------------------
  // read and write decode for the slave
  // ----------------------------------------------------------------

  // read mux, unmapped answers zero with an error
  always_comb begin
    // zero data by default
    rdData = `UIM_RST_VAL;
    rdOk   = 1'b1;
    if (regHit(rdAddr, `UIM_OFF_MASK)) begin
      rdData = core_reg.mask;
    end else if (regHit(rdAddr, `UIM_OFF_RAW)) begin
      rdData = core_reg.raw;
    end else if (regHit(rdAddr, `UIM_OFF_MASKED)) begin
      rdData = maskedVal;
    end else if (regHit(rdAddr, `UIM_OFF_CLEAR)) begin
      rdData = `UIM_RST_VAL;  // write-only, reads zero
    end else begin
      rdOk = 1'b0;
    end
  end

  // writes to any of the four registers are accepted
  assign wrOk = regHit(wrAddr, `UIM_OFF_MASK) ||
                regHit(wrAddr, `UIM_OFF_RAW) ||
                regHit(wrAddr, `UIM_OFF_MASKED) ||
                regHit(wrAddr, `UIM_OFF_CLEAR);

  // interrupt output from its flop
  assign uartIrq = core_reg.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // checks on the bus clock
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // full-word mask write in flight
  sequence maskWordWrite;
    wrStrobe && regHit(wrAddr, `UIM_OFF_MASK) && (wrByteEn == 4'hF);
  endsequence

  // mask takes implemented written bits next cycle
  property maskTakes;
    maskWordWrite |=>
      core_reg.mask == ($past(wrData) & `UIM_IMPL_BITS);
  endproperty

  mask_write_a: assert property (maskTakes)
    else $error("mask did not take written value");

  // a later read returns the mask value stored at that time
  mask_readback_a: assert property (
    maskWordWrite ##[1:8] (rdStrobe && regHit(rdAddr, `UIM_OFF_MASK)
                       && !hitMask)
      |-> rdData == core_reg.mask)
    else $error("mask read differs from stored value");

  // reserved positions never hold a one
  reserved_zero_a: assert property (
    ((core_reg.mask | core_reg.raw) & ~`UIM_IMPL_BITS) == 32'h0000_0000)
    else $error("reserved bit set");

  // reset leaves every flag and enable clear
  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> (core_reg.mask == `UIM_RST_VAL &&
                 core_reg.raw == `UIM_RST_VAL && !uartIrq))
    else $error("state not clear after reset");

  // an event shows in raw status next cycle, mask or not
  raw_sets_a: assert property (
    (evtVec != 32'h0000_0000) |=>
      ((core_reg.raw & $past(evtVec)) == $past(evtVec)))
    else $error("event missing from raw status");

  // writes to raw status leave it as it was
  raw_readonly_a: assert property (
    (wrStrobe && regHit(wrAddr, `UIM_OFF_RAW) && !rdRawClr) |=>
      core_reg.raw == ($past(core_reg.raw) | $past(evtVec)))
    else $error("raw status changed by a write");

  // raw status read returns the pending flags
  raw_read_a: assert property (
    (rdStrobe && regHit(rdAddr, `UIM_OFF_RAW)) |->
      rdOk && rdData == core_reg.raw)
    else $error("raw status read mismatch");

  // masked status read is raw and mask together
  masked_read_a: assert property (
    (rdStrobe && regHit(rdAddr, `UIM_OFF_MASKED)) |->
      rdData == (core_reg.raw & core_reg.mask))
    else $error("masked status read mismatch");

  // a one in the clear register drops that flag
  clear_bit_a: assert property (
    (hitClear && wrByteEn == 4'hF && evtVec == 32'h0000_0000) |=>
      ((core_reg.raw & $past(wrData)) == 32'h0000_0000))
    else $error("clear register did not clear");

  // interrupt line matches any masked flag
  irq_level_a: assert property (
    uartIrq == |(core_reg.raw & core_reg.mask))
    else $error("interrupt level wrong");

  // flags stay set while nothing clears them
  raw_sticky_a: assert property (
    (!hitClear && !rdRawClr) |=>
      ((core_reg.raw & $past(core_reg.raw)) == $past(core_reg.raw)))
    else $error("raw flag dropped without clear");

  // raw status sampled for a read
  sequence rawFetch;
    rdStrobe && regHit(rdAddr, `UIM_OFF_RAW);
  endsequence

  // a raw status read empties what it returned
  raw_empty_a: assert property (
    rawFetch ##0 (evtVec == 32'h0000_0000) |=>
      core_reg.raw == 32'h0000_0000)
    else $error("raw status not emptied by its read");

  // zero clear bits keep their flags
  clear_keep_a: assert property (
    (hitClear && !rdRawClr) |=>
      ((core_reg.raw & $past(core_reg.raw & ~wrData)) ==
       $past(core_reg.raw & ~wrData)))
    else $error("zero clear bit dropped a flag");

endmodule : uim_top

//--- tb/tb_top.sv
// self-checking bench for the uart interrupt mask and status block
`include "uim_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clk, sys_rst;                   // clock and reset
  logic [7:0]  s_axi_awaddr, s_axi_araddr;     // byte addresses
  logic        s_axi_awvalid, s_axi_awready;   // write address channel
  logic [31:0] s_axi_wdata, s_axi_rdata;       // data words
  logic [3:0]  s_axi_wstrb;                    // byte enables
  logic        s_axi_wvalid, s_axi_wready;     // write data channel
  logic [1:0]  s_axi_bresp, s_axi_rresp;       // response codes
  logic        s_axi_bvalid, s_axi_bready;     // write response
  logic        s_axi_arvalid, s_axi_arready;   // read address
  logic        s_axi_rvalid, s_axi_rready;     // read data
  logic [9:0]  evt;                            // source events
  logic        uartIrq;                        // interrupt output
  logic [1:0]  wrQ[$];                         // expected write responses
  logic [33:0] rdQ[$];                         // expected response and data
  int          n_mismatch, n_compared;         // counters
  logic [31:0] m, r;                           // scratch expectations
  // source bit of each event line, in port order
  localparam int SRC_BIT [10] = '{`UIM_BIT_MODEM_CTS, `UIM_BIT_RX,
    `UIM_BIT_TX, `UIM_BIT_RX_TIMEOUT, `UIM_BIT_FRAMING_ERR,
    `UIM_BIT_PARITY_ERR, `UIM_BIT_BREAK_ERR, `UIM_BIT_OVERRUN_ERR,
    `UIM_BIT_FLOW_STOP, `UIM_BIT_TX_FIFO_EMPTY};

  // ----------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------
  uim_top #(.ADDR_W(8)) uim_top_inst (.clk, .sys_rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .modemCtsEvt(evt[0]), .rxEvt(evt[1]), .txEvt(evt[2]),
    .rxTimeoutEvt(evt[3]), .framingErrEvt(evt[4]),
    .parityErrEvt(evt[5]), .breakErrEvt(evt[6]),
    .overrunErrEvt(evt[7]), .flowStopEvt(evt[8]),
    .txFifoEmptyEvt(evt[9]), .uartIrq);

  // clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // compare, verdict
  // ----------------------------------------------------------------
  task automatic cmpData(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: read data %h, expected %h", $time,
               got, exp);
    end
  endtask : cmpData

  task automatic cmpResp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: response %h, expected %h", $time,
               got, exp);
    end
  endtask : cmpResp

  task automatic cmpIrq(input logic exp);
    n_compared++;
    if (uartIrq !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: interrupt %b, expected %b", $time,
               uartIrq, exp);
    end
  endtask : cmpIrq

  task automatic end_of_test;
    n_mismatch += wrQ.size() + rdQ.size();  // unanswered requests
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  // watcher: each handshake takes the oldest note off its queue
  always @(posedge clk) begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
      cmpResp(s_axi_bresp, wrQ.pop_front());
    end
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      cmpResp(s_axi_rresp, rdQ[0][33:32]);
      cmpData(s_axi_rdata, 32'(rdQ.pop_front()));
    end
  end

  // ----------------------------------------------------------------
  // bus and event drivers
  // ----------------------------------------------------------------
  task automatic busWrite(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s, input logic [1:0] resp);
    bit awDone, wDone, bDone;
    @(posedge clk);
    wrQ.push_back(resp);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int i = 0; i < 200 && !bDone; i++) begin
      @(posedge clk);
      // each channel released at the edge that takes it
      if (!awDone && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        awDone = 1'b1;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        wDone = 1'b1;
      end
      if (s_axi_bvalid === 1'b1) begin
        s_axi_bready <= 1'b0;
        bDone = 1'b1;
      end
    end
  endtask : busWrite

  task automatic busRead(input logic [7:0] a, input logic [31:0] d,
                         input logic [1:0] resp);
    bit rDone;
    @(posedge clk);
    rdQ.push_back({resp, d});
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int i = 0; i < 200 && !rDone; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        s_axi_rready <= 1'b0;
        rDone = 1'b1;
      end
    end
  endtask : busRead

  // one-cycle event pulse, then settle until the irq flop follows
  task automatic pulse(input logic [9:0] v);
    @(posedge clk);
    evt <= v;
    @(posedge clk);
    evt <= '0;
    repeat (3) @(posedge clk);
  endtask : pulse

  // expected raw word of an event vector
  function automatic logic [31:0] bitsOf(input logic [9:0] v);
    bitsOf = '0;
    for (int k = 0; k < 10; k++) bitsOf[SRC_BIT[k]] = v[k];
  endfunction : bitsOf

  // watchdog
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    {s_axi_wdata, s_axi_wstrb, evt} = '0;
    void'($urandom(47339));
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    // reset values of the mask, raw and masked status registers
    busRead(`UIM_OFF_MASK, `UIM_RST_VAL, `UIM_RESP_OKAY);
    busRead(`UIM_OFF_RAW, `UIM_RST_VAL, `UIM_RESP_OKAY);
    busRead(`UIM_OFF_MASKED, `UIM_RST_VAL, `UIM_RESP_OKAY);
    cmpIrq(1'b0);
    // each mask bit alone, then random words with reserved bits set
    for (int k = 0; k < 14; k++) begin
      m = (k < 10) ? (32'h0000_0001 << SRC_BIT[k]) : $urandom;
      busWrite(`UIM_OFF_MASK, m, 4'hF, `UIM_RESP_OKAY);
      busRead(`UIM_OFF_MASK, m & `UIM_IMPL_BITS, 0);
    end
    // byte enables limit the mask write to its low byte
    busWrite(`UIM_OFF_MASK, 32'h0000_0000, 4'hF, `UIM_RESP_OKAY);
    busWrite(`UIM_OFF_MASK, 32'hFFFF_FFFF, 4'h1, `UIM_RESP_OKAY);
    busRead(`UIM_OFF_MASK, 32'h0000_00F2, `UIM_RESP_OKAY);
    busWrite(`UIM_OFF_MASK, 32'h0000_0000, 4'hF, `UIM_RESP_OKAY);
    // masked off: raw still set, sticky, read-only, masked zero
    for (int k = 0; k < 10; k++) begin
      pulse(10'h001 << k);
      cmpIrq(1'b0);
      busRead(`UIM_OFF_MASKED, 32'h0000_0000, 0);
      busWrite(`UIM_OFF_RAW, 32'hFFFF_FFFF, 4'hF, 0);
      busRead(`UIM_OFF_RAW, bitsOf(10'h001 << k), 0);
      busRead(`UIM_OFF_RAW, 32'h0000_0000, 0);
    end
    // enabled: masked bit and irq, zero clear ignored, one clears
    busWrite(`UIM_OFF_MASK, `UIM_IMPL_BITS, 4'hF, 0);
    for (int k = 0; k < 10; k++) begin
      m = bitsOf(10'h001 << k);
      pulse(10'h001 << k);
      cmpIrq(1'b1);
      busWrite(`UIM_OFF_CLEAR, ~m, 4'hF, `UIM_RESP_OKAY);
      busRead(`UIM_OFF_MASKED, m, `UIM_RESP_OKAY);
      busWrite(`UIM_OFF_CLEAR, m, 4'hF, `UIM_RESP_OKAY);
      cmpIrq(1'b0);
      busRead(`UIM_OFF_MASKED, 32'h0000_0000, 0);
    end
    // random masks against random event sets
    for (int k = 0; k < 8; k++) begin
      m = $urandom & `UIM_IMPL_BITS;
      r = $urandom;
      busWrite(`UIM_OFF_MASK, m, 4'hF, `UIM_RESP_OKAY);
      pulse(r[9:0]);
      cmpIrq((bitsOf(r[9:0]) & m) != 0);
      busRead(`UIM_OFF_MASKED, bitsOf(r[9:0]) & m, 0);
      busRead(`UIM_OFF_RAW, bitsOf(r[9:0]), 0);
    end
    // unmapped places answer with an error and zero data
    busRead(8'h00, 32'h0000_0000, `UIM_RESP_SLVERR);
    busWrite(8'h10, 32'hFFFF_FFFF, 4'hF, `UIM_RESP_SLVERR);
    busRead(8'h48, 32'h0000_0000, `UIM_RESP_SLVERR);
    repeat (4) @(posedge clk);
    end_of_test();
  end

endmodule : tb_top
